/* inc/icel_defs.vh */
`ifndef ICEL_DEFS_VH
`define ICEL_DEFS_VH
`define ICEL_NCH 4
`define ICEL_CHW 2
`define ICEL_STAT_BASE 8'h00
`define ICEL_CTL_BASE 8'h10
`define ICEL_ADDR_W 8
`define ICEL_CODE_NONE 4'h0
`define ICEL_CODE_EXTRA 4'h3
`define ICEL_CODE_AUTH 4'h4
`define ICEL_CODE_PFLT 4'h5
`define ICEL_CODE_BUS 4'h6
`define ICEL_CODE_SYS 4'h7
`define ICEL_MAP_PFLT 2'h1
`define ICEL_STAT_CODE_LSB 0
`define ICEL_STAT_CODE_MSB 3
`define ICEL_STAT_ERR_BIT 4
`define ICEL_STAT_EN_BIT 5
`define ICEL_CTL_EN_BIT 0
`define ICEL_CTL_PD_BIT 1
`define ICEL_CTL_REC_BIT 2
`endif

/* design/icel_sync.v */
`timescale 1ns/1ps
// three-stage synchroniser; change taken once stages two and three agree
module icel_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire resetn,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
            s3_r <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q <= (s2_r & s3_r) | (q & (s2_r | s3_r));
        end
    end
endmodule

/* design/icel_classify.v */
`timescale 1ns/1ps
`include "icel_defs.vh"
// combinational error classifier for one request
module icel_classify (
    input wire is_master,
    input wire prev_dis,
    input wire bus2bus,
    input wire recov_sys,
    input wire wr_ro,
    input wire pg_fault,
    input wire data_par,
    input wire addr_par,
    input wire no_sfbk,
    input wire no_entry,
    input wire sys_err,
    input wire chck_in,
    output reg [3:0] code,
    output reg hit,
    output reg chck_only
);
    reg quiet;
    always @* begin
        code = `ICEL_CODE_NONE;
        hit = 1'b0;
        chck_only = 1'b0;
        // pd set on master bus-to-bus: address parity and feedback errors suppressed from the log
        quiet = prev_dis & bus2bus;
        if (is_master) begin
            if (wr_ro) begin
                code = `ICEL_CODE_AUTH; // see RULE_06
                hit = 1'b1;
            end else if (pg_fault) begin
                code = `ICEL_CODE_PFLT; // see RULE_07
                hit = 1'b1;
            end else if (data_par && !bus2bus) begin
                code = `ICEL_CODE_BUS; // see RULE_09
                hit = 1'b1;
            end else if (addr_par) begin
                if (quiet) begin
                    chck_only = 1'b1; // see RULE_20
                end else if (!prev_dis || !bus2bus) begin
                    code = `ICEL_CODE_BUS; // see RULE_10
                    hit = 1'b1;
                end
            end else if (no_sfbk && !quiet) begin
                code = `ICEL_CODE_BUS; // see RULE_11
                hit = 1'b1;
            end else if (no_entry || (sys_err && recov_sys)) begin
                code = `ICEL_CODE_SYS; // see RULE_12 RULE_13 RULE_04
                hit = 1'b1;
            end
        end else begin
            if (chck_in) begin
                code = `ICEL_CODE_BUS; // see RULE_15
                hit = 1'b1;
            end else if (data_par) begin
                code = `ICEL_CODE_BUS; // see RULE_16
                hit = 1'b1;
            end else if (no_sfbk && bus2bus) begin
                code = `ICEL_CODE_BUS; // see RULE_17
                hit = 1'b1;
            end else if (no_entry || (sys_err && recov_sys)) begin
                code = `ICEL_CODE_SYS; // see RULE_18 RULE_19 RULE_05
                hit = 1'b1;
            end
        end
    end
endmodule

/* design/icel_top.v */
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "icel_defs.vh"
// Notes on behaviour
// (RULE_01) slave error: class code to status bits 0-3, then terminal count
// (RULE_02) adapter stops DMA and interrupts after the error tc pulse
// (RULE_03) further slave requests get dummy cycles, each with terminal count
// (RULE_04) reload, system address and data errors handled as recoverable
// (RULE_05) recoverable system errors on slave pulse terminal count, log code
// (RULE_06) master write to read-only page logs code 0100
// (RULE_07) master access to page with mapping bits 01 logs 0101
// (RULE_08) master using page faults interrupts after channel check
// (RULE_09) master device-to-memory data parity logs 0110, never bus-to-bus
// (RULE_10) address parity logs 0110 unless prevent bit set on bus-to-bus
// (RULE_11) missing card feedback logs 0110 unless prevent bit on bus-to-bus
// (RULE_12) master access with no translation entry logs 0111
// (RULE_13) master system ECC, bad page number, entry fetch error log 0111
// (RULE_14) request on disabled slave channel logs 0011
// (RULE_15) slave channel check, or async check at start, logs 0110
// (RULE_16) slave data bus parity while reading logs 0110
// (RULE_17) slave missing card feedback logs 0110, second bus-to-bus cycle
// (RULE_18) slave control register 4 entry number without entry logs 0111
// (RULE_19) slave system ECC, bad page, entry fetch error log 0111
// (RULE_20) prevent bit on bus-to-bus: pulse check, no log, no disable; code pulses check for address parity only, not for missing feedback
// (RULE_21) status code holds until software stores to the status register
// (RULE_22) after logging, channel disabled and first code kept until clear
module icel_top #(
    parameter NCH = `ICEL_NCH,
    parameter CHW = `ICEL_CHW
) (
    input wire CLK_SYS,
    input wire RESETN,
    input wire [`ICEL_ADDR_W-1:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [31:0] REG_RDATA,
    input wire REQ_VALID,
    input wire [CHW-1:0] REQ_CH,
    input wire REQ_MASTER,
    input wire REQ_BUS2BUS,
    input wire REQ_SECOND,
    input wire ERR_WR_RO,
    input wire [1:0] ERR_MAP_BITS,
    input wire ERR_DATA_PAR,
    input wire ERR_ADDR_PAR,
    input wire ERR_NO_SFBK,
    input wire ERR_NO_ENTRY,
    input wire ERR_SYS,
    input wire CHCK_IN,
    output reg REQ_DONE,
    output reg REQ_DUMMY,
    output reg TERMINAL_COUNT_PULSE,
    output reg CHCK_PULSE
);
    // the async channel check line comes from the bus pins
    wire chck_sync;
    icel_sync #(.W(1)) u_sync (
        .clk(CLK_SYS),
        .resetn(RESETN),
        .d(CHCK_IN),
        .q(chck_sync)
    );

    reg [3:0] code_r [0:NCH-1];
    reg [NCH-1:0] err_r;
    reg [NCH-1:0] en_r;
    reg [NCH-1:0] pd_r;
    reg [NCH-1:0] rec_r;
    reg [31:0] rdata_nxt;

    wire [CHW-1:0] ch = REQ_CH;
    wire ch_en = en_r[ch];
    wire ch_err = err_r[ch];
    wire ch_pd = pd_r[ch];
    wire ch_rec = rec_r[ch];
    wire pg_fault = (ERR_MAP_BITS == `ICEL_MAP_PFLT);
    // feedback errors on slave only counted on the second bus-to-bus cycle
    wire sfbk_q = ERR_NO_SFBK & (REQ_MASTER | REQ_SECOND);

    wire [3:0] cls_code;
    wire cls_hit;
    wire cls_chck_only;
    icel_classify u_cls (
        .is_master(REQ_MASTER),
        .prev_dis(ch_pd),
        .bus2bus(REQ_BUS2BUS),
        .recov_sys(ch_rec),
        .wr_ro(ERR_WR_RO),
        .pg_fault(pg_fault),
        .data_par(ERR_DATA_PAR),
        .addr_par(ERR_ADDR_PAR),
        .no_sfbk(sfbk_q),
        .no_entry(ERR_NO_ENTRY),
        .sys_err(ERR_SYS),
        .chck_in(chck_sync),
        .code(cls_code),
        .hit(cls_hit),
        .chck_only(cls_chck_only)
    );

    // channel usable only if enabled and nothing logged
    wire ch_live = ch_en & ~ch_err; // see RULE_22
    wire log_now = REQ_VALID & ch_live & cls_hit;
    wire extra_now = REQ_VALID & ~REQ_MASTER & ~ch_live & ~ch_err;
    wire dead_now = REQ_VALID & ~ch_live;

    wire wr_stat = REG_WR &&
        (REG_ADDR[`ICEL_ADDR_W-1:4] == `ICEL_STAT_BASE >> 4);
    wire wr_ctl = REG_WR &&
        (REG_ADDR[`ICEL_ADDR_W-1:4] == `ICEL_CTL_BASE >> 4);
    wire [CHW-1:0] reg_ch = REG_ADDR[CHW+1:2];

    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
            wire sel = (ch == gi);
            wire rsel = (reg_ch == gi);
            always @(posedge CLK_SYS or negedge RESETN) begin
                if (!RESETN) begin
                    code_r[gi] <= `ICEL_CODE_NONE;
                    err_r[gi] <= 1'b0;
                    en_r[gi] <= 1'b0;
                    pd_r[gi] <= 1'b0;
                    rec_r[gi] <= 1'b1;
                end else begin
                    if (wr_ctl && rsel) begin
                        en_r[gi] <= REG_WDATA[`ICEL_CTL_EN_BIT];
                        pd_r[gi] <= REG_WDATA[`ICEL_CTL_PD_BIT];
                        rec_r[gi] <= REG_WDATA[`ICEL_CTL_REC_BIT];
                    end
                    // store clears; a same-cycle log wins over it
                    if (wr_stat && rsel) begin
                        code_r[gi] <= `ICEL_CODE_NONE; // see RULE_21
                        err_r[gi] <= 1'b0;
                    end
                    if (sel && log_now) begin
                        code_r[gi] <= cls_code; // see RULE_01
                        err_r[gi] <= 1'b1; // see RULE_22
                    end else if (sel && extra_now) begin
                        code_r[gi] <= `ICEL_CODE_EXTRA; // see RULE_14
                        err_r[gi] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    always @* begin
        rdata_nxt = 32'h0000_0000;
        if (REG_ADDR[`ICEL_ADDR_W-1:4] == `ICEL_STAT_BASE >> 4) begin
            rdata_nxt[`ICEL_STAT_CODE_MSB:`ICEL_STAT_CODE_LSB] =
                code_r[reg_ch];
            rdata_nxt[`ICEL_STAT_ERR_BIT] = err_r[reg_ch];
            rdata_nxt[`ICEL_STAT_EN_BIT] = en_r[reg_ch];
        end else if (REG_ADDR[`ICEL_ADDR_W-1:4] == `ICEL_CTL_BASE >> 4) begin
            rdata_nxt[`ICEL_CTL_EN_BIT] = en_r[reg_ch];
            rdata_nxt[`ICEL_CTL_PD_BIT] = pd_r[reg_ch];
            rdata_nxt[`ICEL_CTL_REC_BIT] = rec_r[reg_ch];
        end
    end

    // code is written on the request edge, and the pulses are registered on that same edge
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            REG_RDATA <= 32'h0000_0000;
            REQ_DONE <= 1'b0;
            REQ_DUMMY <= 1'b0;
            TERMINAL_COUNT_PULSE <= 1'b0;
            CHCK_PULSE <= 1'b0;
        end else begin
            REG_RDATA <= REG_RD ? rdata_nxt : 32'h0000_0000;
            REQ_DONE <= REQ_VALID;
            REQ_DUMMY <= dead_now & ~REQ_MASTER; // see RULE_03
            TERMINAL_COUNT_PULSE <= REQ_VALID & ~REQ_MASTER &
                (log_now | dead_now); // see RULE_01 RULE_03 RULE_05
            CHCK_PULSE <= REQ_VALID & REQ_MASTER &
                (log_now | dead_now | (ch_live & cls_chck_only)); // see RULE_20
        end
    end
endmodule

/* bench/icel_checker.sv */
`timescale 1ns/1ps
module icel_checker (
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA,
    input wire logic REQ_VALID,
    input wire logic REQ_MASTER,
    input wire logic ERR_WR_RO,
    input wire logic [1:0] ERR_MAP_BITS,
    input wire logic ERR_DATA_PAR,
    input wire logic REQ_DONE,
    input wire logic REQ_DUMMY,
    input wire logic TERMINAL_COUNT_PULSE,
    input wire logic CHCK_PULSE
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);
    AST_DONE: assert property (REQ_VALID |=> REQ_DONE)
        else $error("request not answered");
    AST_TC_SLAVE: assert property (TERMINAL_COUNT_PULSE |->
        $past(REQ_VALID) && !$past(REQ_MASTER)) else $error("stray count");
    AST_CHCK_MASTER: assert property (CHCK_PULSE |->
        $past(REQ_VALID) && $past(REQ_MASTER)) else $error("stray check");
    AST_DUMMY: assert property (REQ_DUMMY |->
        TERMINAL_COUNT_PULSE && REQ_DONE) else $error("dummy without count");
    AST_RO: assert property (REQ_VALID && REQ_MASTER && ERR_WR_RO
        |=> CHCK_PULSE) else $error("read-only write not checked");
    AST_PF: assert property (REQ_VALID && REQ_MASTER
        && ERR_MAP_BITS == 2'h1 |=> CHCK_PULSE) else $error("fault silent");
    AST_DP: assert property (REQ_VALID && !REQ_MASTER
        && ERR_DATA_PAR |=> TERMINAL_COUNT_PULSE) else $error("parity silent");
    AST_RD: assert property (!REG_RD |=> REG_RDATA == 32'h0)
        else $error("read data outside slot");
    cover property (REQ_DUMMY);
    cover property (CHCK_PULSE);
    cover property (REQ_DONE && !TERMINAL_COUNT_PULSE && !CHCK_PULSE);
endmodule
bind icel_top icel_checker chk_u (.*);

/* bench/icel_adapter_model.sv */
`timescale 1ns/1ps
// adapter: interrupts on terminal count or check, raises async check on demand
module icel_adapter_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic term_cnt,
    input wire logic chck,
    input wire logic raise,
    output logic chck_out,
    output logic irq
);
    always @(posedge clk or negedge resetn)
        if (!resetn) irq <= 1'b0;
        else if (term_cnt | chck) irq <= 1'b1;
    always @(posedge clk or negedge resetn)
        if (!resetn) chck_out <= 1'b0;
        else chck_out <= raise;
endmodule

/* bench/io_channel_error_logger_bench.sv */
`timescale 1ns/1ps
`define CHK(n,e,g) begin check_count++; if ((e) !== (g)) begin \
    failures++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module io_channel_error_logger_bench;
    logic CLK_SYS, RESETN, REG_WR, REG_RD, REQ_VALID, REQ_MASTER, CHCK_IN;
    logic REQ_BUS2BUS, REQ_SECOND, ERR_WR_RO, ERR_DATA_PAR, ERR_ADDR_PAR;
    logic ERR_NO_SFBK, ERR_NO_ENTRY, ERR_SYS, REQ_DONE, REQ_DUMMY, raise;
    logic TERMINAL_COUNT_PULSE, CHCK_PULSE, irq;
    logic [1:0] REQ_CH, ERR_MAP_BITS;
    logic [7:0] REG_ADDR;
    logic [31:0] REG_WDATA, REG_RDATA;
    int failures = 0, check_count = 0, cyc = 0;
    icel_top dut_u (.*);
    icel_adapter_model part_u (.clk(CLK_SYS), .resetn(RESETN),
        .term_cnt(TERMINAL_COUNT_PULSE), .chck(CHCK_PULSE), .raise(raise),
        .chck_out(CHCK_IN), .irq(irq));
    initial begin
        CLK_SYS = 0;
        forever #20 CLK_SYS = ~CLK_SYS;
    end
    // run needs well under 1000 cycles
    always @(posedge CLK_SYS) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            complete_run();
        end
    end
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge CLK_SYS);
        {REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, d};
        @(posedge CLK_SYS);
        REG_WR <= 0;
    endtask
    task rd(input [7:0] a, input [31:0] m, input [31:0] e);
        @(posedge CLK_SYS);
        {REG_RD, REG_ADDR} <= {1'b1, a};
        @(posedge CLK_SYS);
        REG_RD <= 0;
        #1;
        `CHK("rdata", e, REG_RDATA & m)
    endtask
    task rq(input [1:0] c, input m, b, s, input [6:0] e);
        @(posedge CLK_SYS);
        {REQ_VALID, REQ_CH, REQ_MASTER, REQ_BUS2BUS, REQ_SECOND} <=
            {1'b1, c, m, b, s};
        {ERR_WR_RO, ERR_MAP_BITS[0], ERR_DATA_PAR, ERR_ADDR_PAR,
            ERR_NO_SFBK, ERR_NO_ENTRY, ERR_SYS} <= e;
        @(posedge CLK_SYS);
        REQ_VALID <= 0;
        #1;
        `CHK("done", 1'b1, REQ_DONE)
    endtask
    // clear, request, pulse on the right line only, then read the code
    task ec(input [1:0] c, input [2:0] ctl, input m, b, s,
            input [6:0] e, input [3:0] code, input p);
        wr(8'h10 + {c, 2'h0}, {29'h0, ctl});
        wr({4'h0, c, 2'h0}, 32'h0);
        rq(c, m, b, s, e);
        `CHK("pulse", p, m ? CHCK_PULSE : TERMINAL_COUNT_PULSE)
        `CHK("other", 1'b0, m ? TERMINAL_COUNT_PULSE : CHCK_PULSE)
        rd({4'h0, c, 2'h0}, 32'hf, {28'h0, code});
    endtask
    task t_reset;
        rd(8'h10, 32'h7, 32'h4);
        rd(8'h00, 32'h3f, 32'h0);
        rd(8'h80, 32'hffff_ffff, 32'h0);
    endtask
    task t_slave;
        ec(0, 5, 0, 0, 0, 7'h00, 4'h0, 0);
        ec(0, 5, 0, 0, 0, 7'h10, 4'h6, 1);
        ec(0, 5, 0, 1, 1, 7'h04, 4'h6, 1);
        ec(0, 5, 0, 0, 0, 7'h01, 4'h7, 1);
        ec(0, 5, 0, 0, 0, 7'h02, 4'h7, 1);
    endtask
    task t_master;
        ec(2, 5, 1, 0, 0, 7'h40, 4'h4, 1);
        ec(2, 5, 1, 0, 0, 7'h20, 4'h5, 1);
        ec(2, 5, 1, 0, 0, 7'h10, 4'h6, 1);
        ec(2, 5, 1, 0, 0, 7'h08, 4'h6, 1);
        ec(2, 5, 1, 0, 0, 7'h04, 4'h6, 1);
        ec(2, 5, 1, 0, 0, 7'h02, 4'h7, 1);
        ec(2, 5, 1, 0, 0, 7'h01, 4'h7, 1);
        ec(2, 7, 1, 1, 0, 7'h08, 4'h0, 1);
        ec(2, 7, 1, 1, 0, 7'h04, 4'h0, 0);
        ec(2, 5, 1, 1, 0, 7'h08, 4'h6, 1);
    endtask
    task t_refuse;
        rq(0, 0, 0, 0, 7'h10);
        `CHK("dummy", 1'b1, REQ_DUMMY)
        `CHK("term_count", 1'b1, TERMINAL_COUNT_PULSE)
        rd(8'h00, 32'h1f, 32'h17);
        wr(8'h00, 32'h0);
        rd(8'h00, 32'h1f, 32'h0);
        ec(1, 0, 0, 0, 0, 7'h00, 4'h3, 1);
        rq(1, 0, 0, 0, 7'h02);
        rd(8'h04, 32'hf, 32'h3);
        ec(3, 0, 1, 0, 0, 7'h00, 4'h0, 1);
    endtask
    task t_chck;
        raise <= 1;
        repeat (6) @(posedge CLK_SYS);
        ec(0, 5, 0, 0, 0, 7'h00, 4'h6, 1);
        raise <= 0;
        repeat (6) @(posedge CLK_SYS);
        `CHK("irq", 1'b1, irq)
    endtask
    initial begin
        {REG_WR, REG_RD, REQ_VALID, REQ_MASTER, REQ_BUS2BUS, REQ_SECOND,
            ERR_WR_RO, ERR_DATA_PAR, ERR_ADDR_PAR, ERR_NO_SFBK,
            ERR_NO_ENTRY, ERR_SYS, raise, RESETN} = 14'h0;
        {REG_ADDR, REG_WDATA, REQ_CH, ERR_MAP_BITS} = 44'h0;
        repeat (3) @(posedge CLK_SYS);
        RESETN <= 1;
        t_reset;
        t_slave;
        t_master;
        t_refuse;
        t_chck;
        complete_run();
    end
endmodule
